// [mfce_master.sv]
// master on the serial line: sends frames, takes reply characters
module mfce_master #(
  parameter int GAP = 20
) (
  // clock
  input wire logic clk,
  // characters towards the block
  output logic rx_valid,
  output logic [7:0] rx_char,
  // reply characters from the block
  input wire logic tx_valid,
  input wire logic [7:0] tx_char,
  output logic tx_ready
);
  timeunit 1ns;
  timeprecision 1ns;
  typedef logic [7:0] mfce_bq_t[$];
  logic slow;
  logic [7:0] got[$];

  // quiet line at start
  initial begin
    slow = 1'b0;
    rx_valid = 1'b0;
    rx_char = 8'h00;
    tx_ready = 1'b1;
  end

  // takes reply characters, stalls at random when slow
  always @(posedge clk) begin
    if (tx_valid && tx_ready) begin
      got.push_back(tx_char);
    end
    tx_ready <= slow ? 1'($urandom_range(0, 1)) : 1'b1;
  end

  // upper-case hex character of a nibble
  function automatic logic [7:0] hx(logic [3:0] n);
    return (n < 4'hA) ? 8'h30 + 8'(n) : 8'h37 + 8'(n);
  endfunction : hx

  // negated byte sum
  function automatic logic [7:0] lrc(mfce_bq_t q);
    logic [7:0] s;
    s = 8'h00;
    foreach (q[i]) s = s + q[i];
    return 8'h00 - s;
  endfunction : lrc

  // reflected crc over all bytes
  function automatic logic [15:0] crc(mfce_bq_t q);
    logic [15:0] c;
    c = 16'hFFFF;
    foreach (q[i]) begin
      c = c ^ {8'h00, q[i]};
      for (int j = 0; j < 8; j++) c = c[0] ? (c >> 1) ^ 16'hA001 : c >> 1;
    end
    return c;
  endfunction : crc

  // one character pulse, then the line shows the inverse
  task automatic put(logic [7:0] b);
    @(posedge clk);
    rx_valid <= 1'b1;
    rx_char <= b;
    @(posedge clk);
    rx_valid <= 1'b0;
    rx_char <= ~b;
  endtask : put

  // ascii frame, check spoilt when bad
  task automatic send_ascii(mfce_bq_t q, logic bad);
    logic [7:0] k;
    k = lrc(q) ^ {7'h00, bad};
    put(8'h3A);
    foreach (q[i]) begin
      put(hx(q[i][7:4]));
      put(hx(q[i][3:0]));
    end
    put(hx(k[7:4]));
    put(hx(k[3:0]));
    put(8'h0D);
    put(8'h0A);
  endtask : send_ascii

  // rtu frame followed by line silence
  task automatic send_rtu(mfce_bq_t q, logic bad);
    logic [15:0] c;
    c = crc(q) ^ {15'h0000, bad};
    foreach (q[i]) put(q[i]);
    put(c[7:0]);
    put(c[15:8]);
    repeat (GAP + 5) @(posedge clk);
  endtask : send_rtu
endmodule : mfce_master

// [mfce_pkg.sv]
package mfce_pkg;
  // framing characters and check constants
  localparam logic [7:0] CHR_START = 8'h3A;
  localparam logic [7:0] CHR_CR = 8'h0D;
  localparam logic [7:0] CHR_LF = 8'h0A;
  localparam logic [7:0] EXC_FLAG = 8'h80;
  localparam logic [15:0] CRC_PRESET = 16'hFFFF;
  localparam logic [15:0] CRC_POLY = 16'hA001;
  localparam logic [15:0] CRC_RESIDUE = 16'h0000;
  localparam logic [7:0] LRC_RESET = 8'h00;
  localparam logic [7:0] LRC_RESIDUE = 8'h00;
  // station address range and word count limit
  localparam logic [7:0] ADDR_MIN = 8'h01;
  localparam logic [7:0] ADDR_MAX = 8'hFE;
  localparam logic [7:0] MAX_WORDS = 8'h09;
  localparam logic [7:0] ZERO_WORDS = 8'h00;
  // shortest accepted frame in bytes, check included
  localparam logic [7:0] MIN_ASC_BYTES = 8'h03;
  localparam logic [7:0] MIN_RTU_BYTES = 8'h04;
  // character positions of an exception reply
  localparam logic [3:0] ASC_LAST_STEP = 4'hA;
  localparam logic [3:0] RTU_LAST_STEP = 4'h4;
  localparam logic [3:0] STEP_CR = 4'h9;
  localparam logic [3:0] STEP_CRC_LO = 4'h3;
  localparam logic [3:0] STEP_CRC_HI = 4'h4;
  // exception codes
  localparam logic [7:0] ERR_NONE = 8'h00;
  localparam logic [7:0] ERR_GROUP = 8'h01;
  localparam logic [7:0] ERR_INDEX = 8'h02;
  localparam logic [7:0] ERR_RANGE = 8'h03;
  localparam logic [7:0] ERR_EXCESS = 8'h04;
  localparam logic [7:0] ERR_ZERO = 8'h05;
  localparam logic [7:0] ERR_WRITE = 8'h06;
  localparam logic [7:0] ERR_ILLEGAL = 8'h27;
  localparam logic [7:0] ERR_PASSWORD = 8'h28;
  localparam logic [7:0] ERR_ENERGIZED = 8'h29;
  // line silence that ends an rtu frame
  localparam int GAP_MS = 10;
  localparam int CLK_HZ = 25_000_000;
  localparam int GAP_CYC = (GAP_MS * CLK_HZ + 999) / 1000;
  // reply buffer shape
  localparam int FIFO_WIDTH = 8;
  localparam int FIFO_DEPTH = 4;

  // verdicts from the parameter logic for one request
  typedef struct packed {
    logic missing_group_fault;
    logic missing_parameter_fault;
    logic range_violation_fault;
    logic illegal_value_fault;
    logic write_protect_fault;
    logic password_fault;
    logic energized_write_block;
    logic [7:0] word_count;
  } mfce_check_t;

  // bytes of an exception reply
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] cmd;
    logic [7:0] code;
  } mfce_reply_t;

  // one byte through the reflected crc, eight shifts
  function automatic logic [15:0] crc_step(input logic [15:0] crc, input logic [7:0] b);
    logic [15:0] c;
    c = crc ^ {8'h00, b};
    for (int i = 0; i < 8; i++) begin
      c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
    end
    return c;
  endfunction : crc_step

  // ascii hex character to {bad, nibble}
  function automatic logic [4:0] hex_decode(input logic [7:0] ch);
    if (ch >= 8'h30 && ch <= 8'h39) begin
      return {1'b0, ch[3:0]};
    end else if (ch >= 8'h41 && ch <= 8'h46) begin
      return {1'b0, 4'(ch[3:0] + 4'h9)};
    end
    return {1'b1, 4'h0};
  endfunction : hex_decode

  // nibble to upper-case ascii hex character
  function automatic logic [7:0] hex_encode(input logic [3:0] n);
    return (n < 4'hA) ? 8'(8'h30 + {4'h0, n}) : 8'(8'h37 + {4'h0, n});
  endfunction : hex_encode

  // first failing check picks the exception code
  function automatic logic [7:0] fault_code(input mfce_check_t c, input logic energized);
    if (c.missing_group_fault) return ERR_GROUP;
    if (c.missing_parameter_fault) return ERR_INDEX;
    if (c.word_count == ZERO_WORDS) return ERR_ZERO;
    if (c.word_count > MAX_WORDS) return ERR_EXCESS;
    if (c.write_protect_fault) return ERR_WRITE;
    if (c.password_fault) return ERR_PASSWORD;
    if (c.energized_write_block && energized) return ERR_ENERGIZED;
    if (c.range_violation_fault) return ERR_RANGE;
    if (c.illegal_value_fault) return ERR_ILLEGAL;
    return ERR_NONE;
  endfunction : fault_code
endpackage : mfce_pkg

// [mfce_top.sv]
// reply character buffer
module mfce_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // filling side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // draining side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_r, wr_nxt, rd_r, rd_nxt;
  logic [AW:0] cnt_r, cnt_nxt;
  logic push, pop;

  // full and empty straight from the fill count
  assign in_ready = cnt_r != (AW + 1)'(DEPTH);
  assign out_valid = cnt_r != '0;
  assign out_data = mem[rd_r];

  // pointer and count next values
  always_comb begin
    push = in_valid && in_ready;
    pop = out_valid && out_ready;
    wr_nxt = wr_r;
    rd_nxt = rd_r;
    if (push) begin
      wr_nxt = (wr_r == AW'(DEPTH - 1)) ? '0 : AW'(wr_r + 1'b1);
    end
    if (pop) begin
      rd_nxt = (rd_r == AW'(DEPTH - 1)) ? '0 : AW'(rd_r + 1'b1);
    end
    cnt_nxt = (AW + 1)'(cnt_r + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop});
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wr_r <= '0;
      rd_r <= '0;
      cnt_r <= '0;
    end else begin
      wr_r <= wr_nxt;
      rd_r <= rd_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  // storage, no reset needed
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_r] <= in_data;
    end
  end
endmodule : mfce_fifo

// How it works
// - ascii check is negated byte sum
// - check sent as two hex characters
// - crc starts from all ones
// - byte xored into crc low byte
// - shift right, xor A001 on one
// - eight shifts per byte, result is crc
// - crc low byte goes out first
// - ascii frame ends on cr then lf
// - rtu frame ends after line silence
// - reply is address, command plus 80, code
// - unknown group gives code 01
// - unknown parameter gives code 02
// - value outside limits gives code 03
// - more than nine words gives 04
// - zero words gives code 05
// - writing read-only parameter gives 06
// - in range but illegal gives 27
// - missing password gives code 28
// - protected write while energized gives 29
// - ascii frame opens with colon
// - station address between 1 and 254
module mfce_top #(
  parameter int GAP_CYCLES = mfce_pkg::GAP_CYC
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // configuration
  input wire logic ascii_mode,
  input wire logic [7:0] station_addr,
  // received characters
  input wire logic rx_valid,
  input wire logic [7:0] rx_char,
  // checked frame stream
  output logic frame_start,
  output logic frame_byte_valid,
  output logic [7:0] frame_byte,
  output logic frame_good,
  output logic frame_bad,
  // fault report from parameter logic
  input wire logic fault_req,
  input wire logic [7:0] fault_cmd,
  input wire mfce_pkg::mfce_check_t fault_check,
  input wire logic servo_energize_input,
  // exception reply characters
  output logic reply_busy,
  output logic tx_valid,
  output logic [7:0] tx_char,
  input wire logic tx_ready
);
  localparam int IW = $clog2(GAP_CYCLES + 1);
  localparam logic [IW-1:0] GAP_END = IW'(GAP_CYCLES);

  typedef enum logic [4:0] {
    RX_IDLE = 5'b00001, RX_HI = 5'b00010, RX_LO = 5'b00100, RX_LF = 5'b01000, RX_RTU = 5'b10000
  } mfce_rx_state_t;
  typedef enum logic [2:0] {TX_IDLE = 3'b001, TX_GAP = 3'b010, TX_SEND = 3'b100} mfce_tx_state_t;

  mfce_rx_state_t rx_st_r, rx_st_nxt;
  mfce_tx_state_t tx_st_r, tx_st_nxt;
  logic [IW-1:0] idle_r, idle_nxt;
  logic [3:0] nib_r, nib_nxt, step_r, step_nxt, sidx;
  logic [7:0] cnt_r, cnt_nxt, lrc_r, lrc_nxt, byte_r, byte_nxt, tbyte, code, sum, byt, tx_ch;
  logic [7:0] lrc_tx_r, lrc_tx_nxt, char_r, char_nxt;
  logic [15:0] crc_r, crc_nxt, crc_tx_r, crc_tx_nxt;
  logic [4:0] hx;
  logic addr_ok_r, addr_ok_nxt, hex_bad_r, hex_bad_nxt, frame_ok_r, frame_ok_nxt;
  logic start_r, start_nxt, bv_r, bv_nxt, good_r, good_nxt, bad_r, bad_nxt;
  logic asc_tx_r, asc_tx_nxt, busy_r, busy_nxt, txv_r, txv_nxt;
  logic son_s1_r, son_s2_r, quiet, take, finish, ok, accept, push, f_ready, f_valid, f_take;
  logic [7:0] f_data;
  mfce_pkg::mfce_reply_t rep_r, rep_nxt;

  assign quiet = idle_r == GAP_END;
  assign frame_start = start_r;
  assign frame_byte_valid = bv_r;
  assign frame_byte = byte_r;
  assign frame_good = good_r;
  assign frame_bad = bad_r;
  assign reply_busy = busy_r;
  assign tx_valid = txv_r;
  assign tx_char = char_r;

  // receive side: framing, byte decode and running checks
  always_comb begin
    rx_st_nxt = rx_st_r;
    nib_nxt = nib_r;
    cnt_nxt = cnt_r;
    lrc_nxt = lrc_r;
    crc_nxt = crc_r;
    addr_ok_nxt = addr_ok_r;
    hex_bad_nxt = hex_bad_r;
    frame_ok_nxt = frame_ok_r && !accept;
    start_nxt = 1'b0;
    bv_nxt = 1'b0;
    byte_nxt = byte_r;
    good_nxt = 1'b0;
    bad_nxt = 1'b0;
    take = 1'b0;
    finish = 1'b0;
    ok = 1'b0;
    tbyte = rx_char;
    hx = mfce_pkg::hex_decode(rx_char);
    idle_nxt = rx_valid ? '0 : (quiet ? idle_r : IW'(idle_r + 1'b1));
    unique case (rx_st_r)
      RX_IDLE: begin
        if (rx_valid && ascii_mode && rx_char == mfce_pkg::CHR_START) begin
          rx_st_nxt = RX_HI;
          start_nxt = 1'b1;
        end else if (rx_valid && !ascii_mode && quiet) begin
          rx_st_nxt = RX_RTU;
          start_nxt = 1'b1;
          take = 1'b1;
        end
      end
      RX_HI: begin
        if (rx_valid && rx_char == mfce_pkg::CHR_START) begin
          start_nxt = 1'b1;
        end else if (rx_valid && rx_char == mfce_pkg::CHR_CR) begin
          rx_st_nxt = RX_LF;
        end else if (rx_valid) begin
          nib_nxt = hx[3:0];
          hex_bad_nxt = hex_bad_r | hx[4];
          rx_st_nxt = RX_LO;
        end
      end
      RX_LO: begin
        if (rx_valid) begin
          hex_bad_nxt = hex_bad_r | hx[4];
          take = 1'b1;
          tbyte = {nib_r, hx[3:0]};
          rx_st_nxt = RX_HI;
        end
      end
      RX_LF: begin
        if (rx_valid) begin
          finish = rx_char == mfce_pkg::CHR_LF;
          bad_nxt = !finish;
          rx_st_nxt = RX_IDLE;
        end
      end
      RX_RTU: begin
        if (rx_valid) begin
          take = 1'b1;
        end else if (quiet) begin
          finish = 1'b1;
        end
      end
      default: rx_st_nxt = RX_IDLE;
    endcase
    // fresh frame clears the accumulators
    if (start_nxt) begin
      lrc_nxt = mfce_pkg::LRC_RESET;
      crc_nxt = mfce_pkg::CRC_PRESET;
      cnt_nxt = '0;
      hex_bad_nxt = 1'b0;
      addr_ok_nxt = 1'b0;
      frame_ok_nxt = 1'b0;
    end
    // each decoded byte feeds both checks
    if (take) begin
      lrc_nxt = 8'(lrc_nxt + tbyte);
      crc_nxt = mfce_pkg::crc_step(crc_nxt, tbyte);
      if (cnt_nxt == '0) begin
        addr_ok_nxt = tbyte == station_addr && station_addr >= mfce_pkg::ADDR_MIN
          && station_addr <= mfce_pkg::ADDR_MAX;
      end
      cnt_nxt = (cnt_nxt == 8'hFF) ? cnt_nxt : 8'(cnt_nxt + 8'h01);
      bv_nxt = 1'b1;
      byte_nxt = tbyte;
    end
    // whole frame including its check sums to the residue
    if (finish) begin
      ok = !hex_bad_r && cnt_r >= (ascii_mode ? mfce_pkg::MIN_ASC_BYTES : mfce_pkg::MIN_RTU_BYTES)
        && (ascii_mode ? lrc_r == mfce_pkg::LRC_RESIDUE : crc_r == mfce_pkg::CRC_RESIDUE);
      good_nxt = ok && addr_ok_r;
      bad_nxt = !ok;
      frame_ok_nxt = ok && addr_ok_r;
      rx_st_nxt = RX_IDLE;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rx_st_r <= RX_IDLE;
      idle_r <= '0;
      nib_r <= '0;
      cnt_r <= '0;
      lrc_r <= mfce_pkg::LRC_RESET;
      crc_r <= mfce_pkg::CRC_PRESET;
      addr_ok_r <= 1'b0;
      hex_bad_r <= 1'b0;
      frame_ok_r <= 1'b0;
      start_r <= 1'b0;
      bv_r <= 1'b0;
      byte_r <= '0;
      good_r <= 1'b0;
      bad_r <= 1'b0;
      son_s1_r <= 1'b0;
      son_s2_r <= 1'b0;
    end else begin
      rx_st_r <= rx_st_nxt;
      idle_r <= idle_nxt;
      nib_r <= nib_nxt;
      cnt_r <= cnt_nxt;
      lrc_r <= lrc_nxt;
      crc_r <= crc_nxt;
      addr_ok_r <= addr_ok_nxt;
      hex_bad_r <= hex_bad_nxt;
      frame_ok_r <= frame_ok_nxt;
      start_r <= start_nxt;
      bv_r <= bv_nxt;
      byte_r <= byte_nxt;
      good_r <= good_nxt;
      bad_r <= bad_nxt;
      son_s1_r <= servo_energize_input;
      son_s2_r <= son_s1_r;
    end
  end

  // exception code and whether a reply is due
  assign code = mfce_pkg::fault_code(fault_check, son_s2_r);
  assign accept = fault_req && tx_st_r == TX_IDLE && frame_ok_r && code != mfce_pkg::ERR_NONE;
  assign sum = 8'(station_addr + fault_cmd + mfce_pkg::EXC_FLAG + code);
  assign sidx = asc_tx_r ? 4'(step_r - 4'h1) : step_r;

  // reply builder: latch the reply, then step through its characters
  always_comb begin
    tx_st_nxt = tx_st_r;
    step_nxt = step_r;
    rep_nxt = rep_r;
    lrc_tx_nxt = lrc_tx_r;
    crc_tx_nxt = crc_tx_r;
    asc_tx_nxt = asc_tx_r;
    push = 1'b0;
    unique case (tx_st_r)
      TX_IDLE: begin
        if (accept) begin
          rep_nxt.addr = station_addr;
          rep_nxt.cmd = 8'(fault_cmd + mfce_pkg::EXC_FLAG);
          rep_nxt.code = code;
          lrc_tx_nxt = 8'(mfce_pkg::LRC_RESET - sum);
          crc_tx_nxt = mfce_pkg::crc_step(mfce_pkg::crc_step(mfce_pkg::crc_step(mfce_pkg::CRC_PRESET,
            station_addr), rep_nxt.cmd), code);
          asc_tx_nxt = ascii_mode;
          step_nxt = '0;
          tx_st_nxt = ascii_mode ? TX_SEND : TX_GAP;
        end
      end
      TX_GAP: begin
        if (quiet) begin
          tx_st_nxt = TX_SEND;
        end
      end
      TX_SEND: begin
        push = 1'b1;
        if (f_ready) begin
          step_nxt = 4'(step_r + 4'h1);
          if (step_r == (asc_tx_r ? mfce_pkg::ASC_LAST_STEP : mfce_pkg::RTU_LAST_STEP)) begin
            tx_st_nxt = TX_IDLE;
          end
        end
      end
      default: tx_st_nxt = TX_IDLE;
    endcase
    busy_nxt = tx_st_nxt != TX_IDLE;
    // character for the current step
    unique case (asc_tx_r ? sidx[2:1] : sidx[1:0])
      2'b00: byt = rep_r.addr;
      2'b01: byt = rep_r.cmd;
      2'b10: byt = rep_r.code;
      default: byt = lrc_tx_r;
    endcase
    if (asc_tx_r) begin
      if (step_r == '0) begin
        tx_ch = mfce_pkg::CHR_START;
      end else if (step_r == mfce_pkg::STEP_CR) begin
        tx_ch = mfce_pkg::CHR_CR;
      end else if (step_r == mfce_pkg::ASC_LAST_STEP) begin
        tx_ch = mfce_pkg::CHR_LF;
      end else begin
        tx_ch = mfce_pkg::hex_encode(sidx[0] ? byt[3:0] : byt[7:4]);
      end
    end else if (step_r == mfce_pkg::STEP_CRC_LO) begin
      tx_ch = crc_tx_r[7:0];
    end else if (step_r == mfce_pkg::STEP_CRC_HI) begin
      tx_ch = crc_tx_r[15:8];
    end else begin
      tx_ch = byt;
    end
  end

  mfce_fifo #(.WIDTH(mfce_pkg::FIFO_WIDTH), .DEPTH(mfce_pkg::FIFO_DEPTH)) u_fifo (
    .clk(clk), .reset_n(reset_n), .in_valid(push), .in_ready(f_ready), .in_data(tx_ch),
    .out_valid(f_valid), .out_ready(f_take), .out_data(f_data)
  );

  // output stage keeps tx pins on flip-flops
  assign f_take = !txv_r || tx_ready;
  always_comb begin
    txv_nxt = f_take ? f_valid : txv_r;
    char_nxt = (f_take && f_valid) ? f_data : char_r;
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      tx_st_r <= TX_IDLE;
      step_r <= '0;
      rep_r <= '0;
      lrc_tx_r <= mfce_pkg::LRC_RESET;
      crc_tx_r <= mfce_pkg::CRC_PRESET;
      asc_tx_r <= 1'b0;
      busy_r <= 1'b0;
      txv_r <= 1'b0;
      char_r <= '0;
    end else begin
      tx_st_r <= tx_st_nxt;
      step_r <= step_nxt;
      rep_r <= rep_nxt;
      lrc_tx_r <= lrc_tx_nxt;
      crc_tx_r <= crc_tx_nxt;
      asc_tx_r <= asc_tx_nxt;
      busy_r <= busy_nxt;
      txv_r <= txv_nxt;
      char_r <= char_nxt;
    end
  end

  // checks on the reply and the receive verdicts
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  reply_lrc_a: assert property (accept |=> 8'(lrc_tx_r + rep_r.addr + rep_r.cmd + rep_r.code) == 8'h00)
    else $error("reply check byte does not cancel the sum");
  rtu_example_a: assert property (tx_st_r == TX_SEND && rep_r == 24'h018602 |-> crc_tx_r == 16'hA1C3)
    else $error("reply crc differs from known vector");
  reply_cmd_a: assert property (accept |=> rep_r.cmd == 8'($past(fault_cmd) + 8'h80))
    else $error("reply command lacks the exception flag");
  group_code_a: assert property (accept && fault_check.missing_group_fault |=> rep_r.code == 8'h01)
    else $error("missing group not reported as 01");
  zero_code_a: assert property (accept && fault_check == 15'h0000 |=> rep_r.code == 8'h05)
    else $error("zero word count not reported as 05");
  bad_drop_a: assert property (bad_r |-> !frame_ok_r ##1 !accept)
    else $error("reply armed by a bad frame");
  rtu_gap_a: assert property ($rose(tx_st_r == TX_SEND) && !asc_tx_r |-> $past(quiet))
    else $error("rtu reply started without line silence");
  crc_residue_a: assert property (good_r && !$past(ascii_mode) |-> $past(crc_r) == 16'h0000)
    else $error("rtu frame accepted with wrong crc");
  ascii_tail_a: assert property (push && f_ready && asc_tx_r && step_r == 4'hA
    |-> tx_ch == 8'h0A ##1 tx_st_r == TX_IDLE)
    else $error("ascii reply not closed by line feed");
  good_ascii_c: cover property (good_r && ascii_mode);
  good_rtu_c: cover property (good_r && !ascii_mode);
  bad_frame_c: cover property (bad_r);
  reply_out_c: cover property (accept ##[1:40] txv_r);
endmodule : mfce_top

// [modbus_frame_check_and_exception_test.sv]
module modbus_frame_check_and_exception_test;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int GAP = 20;
  localparam logic [7:0] CODES[11] = '{8'h01, 8'h02, 8'h05, 8'h04, 8'h06, 8'h28, 8'h29, 8'h03, 8'h27, 8'h00, 8'h00};
  logic clk, reset_n, ascii_mode, rx_valid, fault_req, servo_energize_input, tx_ready;
  logic frame_start, frame_byte_valid, frame_good, frame_bad, reply_busy, tx_valid;
  logic [7:0] station_addr, rx_char, frame_byte, fault_cmd, tx_char, last_cmd;
  mfce_pkg::mfce_check_t fault_check;
  int fail_count, tests_run, cycles, goods, bads, starts;
  logic [7:0] fb_q[$];

  mfce_top #(.GAP_CYCLES(GAP)) u_dut (.clk(clk), .reset_n(reset_n), .ascii_mode(ascii_mode),
    .station_addr(station_addr), .rx_valid(rx_valid), .rx_char(rx_char), .frame_start(frame_start),
    .frame_byte_valid(frame_byte_valid), .frame_byte(frame_byte), .frame_good(frame_good),
    .frame_bad(frame_bad), .fault_req(fault_req), .fault_cmd(fault_cmd), .fault_check(fault_check),
    .servo_energize_input(servo_energize_input), .reply_busy(reply_busy), .tx_valid(tx_valid),
    .tx_char(tx_char), .tx_ready(tx_ready));
  mfce_master #(.GAP(GAP)) u_master (.clk(clk), .rx_valid(rx_valid), .rx_char(rx_char),
    .tx_valid(tx_valid), .tx_char(tx_char), .tx_ready(tx_ready));

  // clock
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // frame monitor and hang guard
  always @(posedge clk) begin
    cycles++;
    if (frame_good === 1'b1) goods++;
    if (frame_bad === 1'b1) bads++;
    if (frame_start === 1'b1) starts++;
    if (frame_byte_valid === 1'b1) fb_q.push_back(frame_byte);
    if (cycles == 20000) begin
      fail_count++;
      close_out();
    end
  end

  task automatic close_out();
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : close_out

  task automatic check_byte(string what, logic [7:0] exp, logic [7:0] seen);
    tests_run++;
    if (seen !== exp) begin
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      fail_count++;
    end
  endtask : check_byte

  task automatic check_count(string what, int exp, int seen);
    tests_run++;
    if (seen != exp) begin
      $display("CHECK FAILED %s expected %0d seen %0d", what, exp, seen);
      fail_count++;
    end
  endtask : check_count

  // verdict pattern that should yield table entry i
  function automatic mfce_pkg::mfce_check_t mk_check(int i);
    mfce_pkg::mfce_check_t c;
    c = '0;
    c.word_count = (i == 9) ? 8'h09 : 8'h01;
    case (i)
      0: c.missing_group_fault = 1'b1;
      1: c.missing_parameter_fault = 1'b1;
      2: c.word_count = 8'h00;
      3: c.word_count = 8'h0A;
      4: c.write_protect_fault = 1'b1;
      5: c.password_fault = 1'b1;
      6, 10: c.energized_write_block = 1'b1;
      7: c.range_violation_fault = 1'b1;
      8: c.illegal_value_fault = 1'b1;
      default: c.word_count = 8'h09;
    endcase
    return c;
  endfunction : mk_check

  // random frame to addr, optional spoilt check
  task automatic run_frame(logic [7:0] addr, logic bad);
    logic [7:0] q[$];
    logic [7:0] e[$];
    logic [15:0] c;
    q = {addr, 8'($urandom_range(1, 127))};
    repeat (4) q.push_back(8'($urandom));
    last_cmd = q[1];
    fb_q = {};
    goods = 0;
    bads = 0;
    starts = 0;
    if (ascii_mode) begin
      u_master.send_ascii(q, bad);
      e = {q, u_master.lrc(q)};
    end else begin
      u_master.send_rtu(q, bad);
      c = u_master.crc(q);
      e = {q, c[7:0], c[15:8]};
    end
    repeat (3) @(posedge clk);
    check_count("good pulses", (addr == station_addr && !bad) ? 1 : 0, goods);
    check_count("bad pulses", bad ? 1 : 0, bads);
    check_count("start pulses", 1, starts);
    if (!bad && addr == station_addr) begin
      check_count("frame bytes", e.size(), fb_q.size());
      foreach (e[k]) check_byte("frame byte", e[k], (k < fb_q.size()) ? fb_q[k] : 8'hXX);
    end
  endtask : run_frame

  // exception request and reply comparison
  task automatic fault(int i, logic [7:0] code);
    logic [7:0] h[$];
    logic [7:0] e[$];
    logic [7:0] k;
    logic [15:0] c;
    int n;
    e = {};
    // command 06 with code 02 gives the known reply vector
    if (i == 1) last_cmd = 8'h06;
    if (code != 8'h00) begin
      h = {station_addr, last_cmd + 8'h80, code};
      if (ascii_mode) begin
        k = u_master.lrc(h);
        e = {8'h3A};
        foreach (h[j]) e = {e, u_master.hx(h[j][7:4]), u_master.hx(h[j][3:0])};
        e = {e, u_master.hx(k[7:4]), u_master.hx(k[3:0]), 8'h0D, 8'h0A};
      end else begin
        c = u_master.crc(h);
        e = {h, c[7:0], c[15:8]};
      end
    end
    u_master.got = {};
    servo_energize_input <= (i == 6);
    repeat (3) @(posedge clk);
    fault_check <= mk_check(i);
    fault_cmd <= last_cmd;
    fault_req <= 1'b1;
    @(posedge clk);
    fault_req <= 1'b0;
    @(posedge clk);
    check_byte("reply busy", {7'h00, code != 8'h00}, {7'h00, reply_busy});
    n = 0;
    while (n < 300 && u_master.got.size() < e.size()) begin
      @(posedge clk);
      n++;
    end
    repeat (20) @(posedge clk);
    check_byte("reply idle", 8'h00, {7'h00, reply_busy});
    check_count("reply length", e.size(), u_master.got.size());
    if (i == 1 && u_master.got.size() == e.size()) begin
      check_byte("known check lo", ascii_mode ? 8'h37 : 8'hC3, u_master.got[ascii_mode ? 7 : 3]);
      check_byte("known check hi", ascii_mode ? 8'h37 : 8'hA1, u_master.got[ascii_mode ? 8 : 4]);
    end
    foreach (e[j]) check_byte("reply char", e[j], (j < u_master.got.size()) ? u_master.got[j] : 8'hXX);
  endtask : fault

  // main sequence: ascii then rtu with a stalling receiver
  initial begin
    void'($urandom(39664));
    reset_n = 1'b0;
    ascii_mode = 1'b1;
    station_addr = 8'h01;
    fault_req = 1'b0;
    fault_cmd = 8'h00;
    fault_check = '0;
    servo_energize_input = 1'b0;
    fail_count = 0;
    tests_run = 0;
    cycles = 0;
    repeat (5) @(posedge clk);
    reset_n <= 1'b1;
    for (int m = 0; m < 2; m++) begin
      ascii_mode <= (m == 0);
      u_master.slow = (m == 1);
      repeat (GAP + 3) @(posedge clk);
      for (int i = 0; i < 11; i++) begin
        run_frame(8'h01, 1'b0);
        fault(i, CODES[i]);
      end
      run_frame(8'h01, 1'b1);
      fault(0, 8'h00);
      run_frame(8'h02, 1'b0);
    end
    close_out();
  end
endmodule : modbus_frame_check_and_exception_test
